/* include/fpec_map.svh */
// register offsets, field positions, reset values and timing constants
// assumes inclusion by bare name from design files
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
`define FPEC_OFS_ADDR 12'h000
`define FPEC_OFS_DATA 12'h004
`define FPEC_OFS_CTRL 12'h008
`define FPEC_OFS_TICK 12'h140
`define FPEC_OFS_RDAT 12'h00C
`define FPEC_TICK_RST 8'h31
`define FPEC_KEY 16'hA442
`define FPEC_KEY_LSB 16
`define FPEC_REQ_PROG 0
`define FPEC_REQ_PERS 1
`define FPEC_REQ_MERS 2
`define FPEC_REQ_SAVE 3
`define FPEC_WORD_ALIGN 32'hFFFF_FFFC
`define FPEC_PAGE_ALIGN 32'hFFFF_FC00
`define FPEC_PROG_US 16'h0014
`define FPEC_PERS_US 16'h2710
`define FPEC_MERS_US 16'h2710
`define FPEC_SAVE_US 16'h0032
`endif

/* include/fpec_pkg.sv */
// types for the flash program and erase sequencer
// assumes fpec_map.svh for numeric constants
package fpec_pkg;
	typedef enum logic [1:0] {
		FPEC_IDLE = 2'b00,
		FPEC_PULSE = 2'b01,
		FPEC_DONE = 2'b10
	} fpec_state_t;
	typedef enum logic [1:0] {
		FPEC_OP_PROG = 2'b00,
		FPEC_OP_PERS = 2'b01,
		FPEC_OP_MERS = 2'b10,
		FPEC_OP_SAVE = 2'b11
	} fpec_op_t;
endpackage

/* src/fpec_pulse.sv */
// high-voltage pulse timer counting microsecond ticks
// assumes tick is a one-cycle pulse
`timescale 1ns/1ns
module fpec_pulse #(
	parameter int CW = 16
) (
	input wire logic core_clk, // system clock
	input wire logic rst_n, // sync reset, low
	input wire logic start, // load and begin timing
	input wire logic tick, // microsecond tick
	input wire logic [CW-1:0] len_us, // pulse length in ticks
	output logic busy, // pulse in progress
	output logic done // one-cycle end pulse
);
	logic [CW-1:0] left_r;
	logic busy_r;
	wire last = busy_r && tick && (left_r == {{(CW-1){1'b0}}, 1'b1});
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			left_r <= '0;
		end else if (start) begin
			busy_r <= 1'b1;
			left_r <= len_us;
		end else if (busy_r && tick) begin
			left_r <= left_r - 1'b1;
			if (last) begin
				busy_r <= 1'b0;
			end
		end
	end
	assign busy = busy_r;
	assign done = last;
endmodule

/* src/fpec_tick.sv */
// microsecond tick divider
// assumes reload value is frequency in MHz minus one
`timescale 1ns/1ns
module fpec_tick #(
	parameter int RW = 8
) (
	input wire logic core_clk, // system clock
	input wire logic rst_n, // sync reset, low
	input wire logic run, // count while high
	input wire logic [RW-1:0] reload, // cycles per tick minus one
	output logic tick // one-cycle pulse every microsecond
);
	logic [RW-1:0] cnt_r;
	wire expire = (cnt_r == '0);
	always_ff @(posedge core_clk) begin
		if (!rst_n || !run) begin
			cnt_r <= reload;
		end else if (expire) begin
			cnt_r <= reload;
		end else begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
	assign tick = run && expire;
endmodule

/* src/fpec_top.sv */
// flash program and erase sequencer with register port
// assumes a flash array port that stores words and clears pages
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "fpec_map.svh"
module fpec_top #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input wire logic core_clk, // system clock, 50 MHz
	input wire logic rst_n, // sync reset, low
	input wire logic [11:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	output logic [AW-1:0] fl_addr, // array address
	output logic [DW-1:0] fl_wdata, // array write word
	output logic fl_prog, // program pulse level
	output logic fl_page_clr, // page erase pulse level
	output logic fl_mass_clr, // mass erase pulse level
	output logic fl_save, // protection save pulse level
	output logic fl_rd, // array read request
	input wire logic [DW-1:0] fl_rdata, // array read word
	input wire logic fl_exec_only // addressed block is execute-only
);
	// =========================================
	// register decode
	fpec_pkg::fpec_state_t state_r, state_nxt;
	fpec_pkg::fpec_op_t op_r;
	logic [AW-1:0] addr_r;
	logic [DW-1:0] data_r;
	logic [7:0] tick_r;
	logic [3:0] req_r;
	logic [31:0] rdata_r;
	logic [15:0] len_r;
	logic rd_pend_r;
	logic start_r;
	wire st_idle = (state_r == fpec_pkg::FPEC_IDLE);
	wire st_pulse = (state_r == fpec_pkg::FPEC_PULSE);
	wire st_done = (state_r == fpec_pkg::FPEC_DONE);
	wire busy = !st_idle;
	wire sel_addr = (reg_addr == `FPEC_OFS_ADDR);
	wire sel_data = (reg_addr == `FPEC_OFS_DATA);
	wire sel_ctrl = (reg_addr == `FPEC_OFS_CTRL);
	wire sel_tick = (reg_addr == `FPEC_OFS_TICK);
	wire sel_rdat = (reg_addr == `FPEC_OFS_RDAT);
	// a launch in flight already counts as busy, so a back-to-back
	// keyed write cannot restart the pulse before leaving idle
	wire hold = busy || start_r;
	wire key_ok = (reg_wdata[31:16] == `FPEC_KEY);
	wire [3:0] req_w = reg_wdata[3:0];
	wire any_req = (req_w != 4'h0);
	wire ctrl_hit = reg_wr && sel_ctrl && key_ok;
	wire ctrl_go = ctrl_hit && any_req && !hold;
	// =========================================
	// write enables
	wire wr_addr = reg_wr && sel_addr && !hold;
	wire wr_data = reg_wr && sel_data && !hold;
	wire wr_tick = reg_wr && sel_tick;
	wire wr_fetch = reg_wr && sel_rdat && !hold;
	wire [DW-1:0] fetch_w = fl_exec_only ? '0 : fl_rdata;
	// =========================================
	// operation select
	fpec_pkg::fpec_op_t op_w;
	logic [15:0] len_w;
	always_comb begin
		op_w = fpec_pkg::FPEC_OP_PROG;
		len_w = `FPEC_PROG_US;
		if (req_w[`FPEC_REQ_PROG]) begin
			op_w = fpec_pkg::FPEC_OP_PROG;
			len_w = `FPEC_PROG_US;
		end else if (req_w[`FPEC_REQ_PERS]) begin
			op_w = fpec_pkg::FPEC_OP_PERS;
			len_w = `FPEC_PERS_US;
		end else if (req_w[`FPEC_REQ_MERS]) begin
			op_w = fpec_pkg::FPEC_OP_MERS;
			len_w = `FPEC_MERS_US;
		end else begin
			op_w = fpec_pkg::FPEC_OP_SAVE;
			len_w = `FPEC_SAVE_US;
		end
	end
	// =========================================
	// registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			start_r <= 1'b0;
		end else begin
			start_r <= ctrl_go;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_r <= '0;
		end else if (wr_addr) begin
			addr_r <= reg_wdata[AW-1:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			data_r <= '0;
		end else if (wr_data) begin
			data_r <= reg_wdata[DW-1:0];
		end else if (rd_pend_r) begin
			data_r <= fetch_w;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tick_r <= `FPEC_TICK_RST;
		end else if (wr_tick) begin
			tick_r <= reg_wdata[7:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			req_r <= 4'h0;
			op_r <= fpec_pkg::FPEC_OP_PROG;
			len_r <= '0;
		end else if (ctrl_go) begin
			req_r <= req_w;
			op_r <= op_w;
			len_r <= len_w;
		end else if (st_done) begin
			req_r <= 4'h0;
		end
	end
	// =========================================
	// read path: a write to the RDAT offset (12'h00C) triggers an array fetch into the data register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_pend_r <= 1'b0;
		end else begin
			rd_pend_r <= wr_fetch;
		end
	end
	assign fl_rd = rd_pend_r;
	wire [31:0] rd_addr_w = 32'(addr_r);
	wire [31:0] rd_data_w = 32'(data_r);
	wire [31:0] rd_ctrl_w = {16'h0000, 12'h000, req_r};
	wire [31:0] rd_tick_w = {24'h00_0000, tick_r};
	wire [31:0] rd_mux = sel_addr ? rd_addr_w :
		sel_data ? rd_data_w :
		sel_ctrl ? rd_ctrl_w :
		sel_tick ? rd_tick_w : 32'h0000_0000;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_r;
	// =========================================
	// sequencer
	logic tick;
	logic pulse_busy;
	logic pulse_done;
	fpec_tick #(.RW(8)) u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(busy),
		.reload(tick_r),
		.tick(tick)
	);
	fpec_pulse #(.CW(16)) u_pulse (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(start_r),
		.tick(tick),
		.len_us(len_r),
		.busy(pulse_busy),
		.done(pulse_done)
	);
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			fpec_pkg::FPEC_IDLE: begin
				if (start_r) begin
					state_nxt = fpec_pkg::FPEC_PULSE;
				end
			end
			fpec_pkg::FPEC_PULSE: begin
				if (pulse_done) begin
					state_nxt = fpec_pkg::FPEC_DONE;
				end
			end
			fpec_pkg::FPEC_DONE: begin
				state_nxt = fpec_pkg::FPEC_IDLE;
			end
			default: begin
				state_nxt = fpec_pkg::FPEC_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= fpec_pkg::FPEC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	// =========================================
	// array drive
	wire in_pulse = st_pulse && pulse_busy;
	// page address only while a page erase runs, so later fetches
	// go back to the word address
	wire is_pers = busy && (op_r == fpec_pkg::FPEC_OP_PERS);
	wire is_prog = (op_r == fpec_pkg::FPEC_OP_PROG);
	wire [AW-1:0] word_a = addr_r & AW'(`FPEC_WORD_ALIGN);
	wire [AW-1:0] page_a = addr_r & AW'(`FPEC_PAGE_ALIGN);
	wire [AW-1:0] addr_w = is_pers ? page_a : word_a;
	wire [DW-1:0] wdata_w = is_prog ? data_r : '0;
	wire [3:0] pulse_w = in_pulse ? req_r : 4'h0;
	logic [AW-1:0] fl_addr_r;
	logic [DW-1:0] fl_wdata_r;
	logic [3:0] fl_op_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fl_addr_r <= '0;
		end else begin
			fl_addr_r <= addr_w;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fl_wdata_r <= '0;
		end else begin
			fl_wdata_r <= wdata_w;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fl_op_r <= 4'h0;
		end else begin
			fl_op_r <= pulse_w;
		end
	end
	assign fl_addr = fl_addr_r;
	assign fl_wdata = fl_wdata_r;
	assign fl_prog = fl_op_r[`FPEC_REQ_PROG];
	assign fl_page_clr = fl_op_r[`FPEC_REQ_PERS];
	assign fl_mass_clr = fl_op_r[`FPEC_REQ_MERS];
	assign fl_save = fl_op_r[`FPEC_REQ_SAVE];
endmodule

/* verif/fpec_flash_model.sv */
// behavioural flash array on the sequencer's far side
// assumes registered pulse levels and one-cycle read requests
`timescale 1ns/1ns
module fpec_flash_model (
	input wire logic core_clk, // clock
	input wire logic [31:0] fl_addr, // address
	input wire logic [31:0] fl_wdata, // word
	input wire logic fl_prog, // program
	input wire logic fl_page_clr, // page erase
	input wire logic fl_mass_clr, // mass erase
	input wire logic fl_rd, // read
	output logic [31:0] fl_rdata, // read word
	output logic fl_exec_only // exec-only block
);
	// ==========
	// one page of words, erased to ones
	logic [31:0] mem [0:255];
	logic [31:0] junk_r = 32'h5A5A_5A5A;
	assign fl_exec_only = fl_addr[15];
	// bus shows a toggling pattern when not read
	assign fl_rdata = fl_rd ? mem[fl_addr[9:2]] : junk_r;
	initial for (int i = 0; i < 256; i++) mem[i] = 32'hFFFF_FFFF;
	always @(posedge core_clk) begin
		junk_r <= ~junk_r;
		if (fl_prog)
			mem[fl_addr[9:2]] <= mem[fl_addr[9:2]] & fl_wdata;
		if (fl_page_clr || fl_mass_clr)
			for (int i = 0; i < 256; i++) mem[i] <= 32'hFFFF_FFFF;
	end
endmodule

/* verif/fpec_top_properties.sv */
// port checker for the flash sequencer
// assumes binding to fpec_top
`timescale 1ns/1ns
module fpec_top_checker #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset
	input wire logic [11:0] reg_addr, // address
	input wire logic [31:0] reg_wdata, // wdata
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [31:0] reg_rdata, // rdata
	input wire logic [AW-1:0] fl_addr, // array addr
	input wire logic [DW-1:0] fl_wdata, // array word
	input wire logic fl_prog, // program
	input wire logic fl_page_clr, // page erase
	input wire logic fl_mass_clr, // mass erase
	input wire logic fl_save, // commit
	input wire logic fl_rd, // array read
	input wire logic [DW-1:0] fl_rdata, // array data
	input wire logic fl_exec_only // exec-only
);
	// ==========
	// assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
	property p_key; reg_rd && reg_addr == 12'h008 |=> !(|reg_rdata[31:16]);
	endproperty
	a_key: assert property (p_key) else $error("key readable");
	property p_tick; reg_rd && reg_addr == 12'h140 |=> !(|reg_rdata[31:8]);
	endproperty
	a_tick: assert property (p_tick) else $error("tick upper set");
	property p_hold; fl_prog && $past(fl_prog) |-> $stable({fl_addr, fl_wdata});
	endproperty
	a_hold: assert property (p_hold) else $error("moved in pulse");
	property p_word; fl_prog |-> fl_addr[1:0] == 2'h0; endproperty
	a_word: assert property (p_word) else $error("word misaligned");
	property p_page; fl_page_clr |-> fl_addr[9:0] == 10'h000; endproperty
	a_page: assert property (p_page) else $error("page misaligned");
	property p_edat; fl_page_clr || fl_mass_clr |-> fl_wdata == '0; endproperty
	a_edat: assert property (p_edat) else $error("erase data used");
	property p_one; $onehot0({fl_prog, fl_page_clr, fl_mass_clr, fl_save});
	endproperty
	a_one: assert property (p_one) else $error("two pulses");
	property p_len; $rose(fl_prog) |-> fl_prog [*8]; endproperty
	a_len: assert property (p_len) else $error("pulse short");
	c_prog: cover property ($rose(fl_prog));
	c_page: cover property ($rose(fl_page_clr));
	c_mass: cover property ($rose(fl_mass_clr));
	c_save: cover property ($rose(fl_save));
endmodule

/* verif/tb_top.sv */
// self-checking bench for the flash sequencer
// assumes the flash model and the port checker
`timescale 1ns/1ns
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, fl_addr, fl_wdata, fl_rdata, d, a, v;
	logic fl_prog, fl_page_clr, fl_mass_clr, fl_save, fl_rd, fl_exec_only;
	logic [3:0] seen = 4'h0;
	int errors = 0;
	int n_compared = 0;
	int seed = 65;
	int plen = 0;
	always #5 core_clk = ~core_clk;
	fpec_top fpec_top_inst (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .fl_prog(fl_prog), .fl_page_clr(fl_page_clr),
		.fl_mass_clr(fl_mass_clr), .fl_save(fl_save), .fl_rd(fl_rd),
		.fl_rdata(fl_rdata), .fl_exec_only(fl_exec_only));
	fpec_flash_model fpec_flash_model_inst (.core_clk(core_clk),
		.fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_prog(fl_prog),
		.fl_page_clr(fl_page_clr), .fl_mass_clr(fl_mass_clr),
		.fl_rd(fl_rd), .fl_rdata(fl_rdata), .fl_exec_only(fl_exec_only));
	always @(posedge core_clk) begin
		seen <= seen | {fl_save, fl_mass_clr, fl_page_clr, fl_prog};
		plen <= plen + int'(fl_prog);
	end
	// ==========
	// tasks
	function automatic int exp_cycles(input int us, input int rl);
		return us * (rl + 1);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] ad,
		input logic [31:0] wd);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= ad;
		reg_wdata <= wd;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic op(input int b, input logic [31:0] ae);
		seen = 4'h0;
		plen = 0;
		bus(1, 12'h008, 32'hA442_0000 | (32'h1 << b));
		bus(0, 12'h008, 0);
		chk(d, 32'h1 << b);
		bus(1, 12'h000, ae ^ 32'h0000_0400);
		bus(1, 12'h008, 32'hA442_0000 | (32'h1 << ((b + 1) % 4)));
		d = 32'hFFFF_FFFF; // force at least one poll
		for (int i = 0; i < 12000 && d !== 0; i++) bus(0, 12'h008, 0);
		chk(d, 0);
		chk({28'h0, seen}, 32'h1 << b);
		bus(0, 12'h000, 0);
		chk(d, ae);
	endtask
	task automatic finish_test;
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========
	// scenarios
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(0, 12'h140, 0);
		chk(d, 32'h0000_0031);
		bus(1, 12'h140, 32'hFFFF_FF03);
		bus(0, 12'h140, 0);
		chk(d, 32'h0000_0003);
		bus(0, 12'h0F0, 0);
		chk(d, 0);
		bus(1, 12'h008, 32'hA443_0001);
		bus(0, 12'h008, 0);
		chk(d, 0);
		for (int i = 0; i < 3; i++) begin
			a = ($random(seed) & 32'h0000_03F0) | (i << 2);
			v = $random(seed);
			bus(1, 12'h004, v);
			bus(1, 12'h000, a);
			op(0, a);
			chk(plen, exp_cycles(20, 3));
			bus(1, 12'h00C, 0);
			bus(0, 12'h004, 0);
			chk(d, v);
		end
		bus(1, 12'h000, a | 32'h0000_8000);
		bus(1, 12'h00C, 0);
		bus(0, 12'h004, 0);
		chk(d, 0);
		bus(1, 12'h140, 0);
		bus(1, 12'h000, 32'h0000_0400);
		op(1, 32'h0000_0400);
		bus(1, 12'h00C, 0);
		bus(0, 12'h004, 0);
		chk(d, 32'hFFFF_FFFF);
		op(2, 32'h0000_0400);
		op(3, 32'h0000_0400);
		finish_test;
	end
	initial begin
		#1_000_000;
		errors++;
		finish_test;
	end
endmodule
bind fpec_top fpec_top_checker #(.AW(AW), .DW(DW)) fpec_top_checker_inst (
	.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
	.fl_prog(fl_prog), .fl_page_clr(fl_page_clr), .fl_mass_clr(fl_mass_clr),
	.fl_save(fl_save), .fl_rd(fl_rd), .fl_rdata(fl_rdata),
	.fl_exec_only(fl_exec_only));
